// ==== design/amd_pkg.sv ====
// Constants and types for the accumulator and memory-reference instruction decoder.
package amd_pkg;
	// Program counter value after reset.
	localparam logic [15:0] PC_RESET = 16'h0000;
	// Field positions inside an instruction word.
	localparam int SHIFT_LSB = 8;
	localparam int MODE_BIT = 7;
	localparam int ADDR_MSB = 6;
	localparam int BYTE_MSB = 7;
	// A word matches an opcode when its bits under the mask equal the pattern.
	localparam logic [15:0] MSK_NIBBLE = 16'hF000;
	localparam logic [15:0] MSK_TOP5 = 16'hF800;
	localparam logic [15:0] MSK_BYTE = 16'hFF00;
	localparam logic [15:0] MSK_LONG = 16'hF0FF;
	localparam logic [15:0] MSK_NORMALIZE_OP = 16'hFF0F;
	localparam logic [15:0] MSK_WORD = 16'hFFFF;
	localparam logic [15:0] PAT_SUM = 16'h0000;
	localparam logic [15:0] PAT_LOAD = 16'h2000;
	localparam logic [15:0] PAT_HSTORE = 16'h6800;
	localparam logic [15:0] PAT_LSUM = 16'hD002;
	localparam logic [15:0] PAT_LLOAD = 16'hD001;
	localparam logic [15:0] PAT_LAND = 16'hD004;
	localparam logic [15:0] PAT_LOR = 16'hD005;
	localparam logic [15:0] PAT_HSUM = 16'h4800;
	localparam logic [15:0] PAT_USUM = 16'h4900;
	localparam logic [15:0] PAT_TSUM = 16'h4A00;
	localparam logic [15:0] PAT_CSUM = 16'h4300;
	localparam logic [15:0] PAT_ABS = 16'hCE1B;
	localparam logic [15:0] PAT_NORMALIZE_OP = 16'hCE02;
	localparam logic [15:0] PAT_SLOAD = 16'hCA00;
	localparam logic [15:0] PAT_SSUM = 16'hCC00;
	// Branch, port and call class decoded only for its cycle count.
	localparam logic [15:0] PAT_MULTI = 16'hF000;
	// Extra cycles added after a multicycle instruction.
	localparam logic [1:0] MULTI_EXTRA = 2'h2;
	// Extra cycle when an external operand and an external fetch share the data lines.
	localparam logic [1:0] SHARE_EXTRA = 2'h1;

	typedef enum logic [4:0] {
		noOp,
		accSumOp,
		shiftedLoadOp,
		upperHalfStoreOp,
		longImmSumOp,
		longImmLoadOp,
		longImmConjunctionOp,
		longImmDisjunctionOp,
		upperHalfSumOp,
		unsignedLowSumOp,
		tregShiftSumOp,
		carrySumOp,
		absoluteValueOp,
		normalizeOp,
		shortImmLoadOp,
		shortImmSumOp,
		multiCycleOp,
		otherOp
	} amd_op_t;

	typedef enum logic [1:0] {
		sStart,
		sWait,
		sHold
	} amd_state_t;
endpackage : amd_pkg

// ==== design/amd_decoder.sv ====
// Instruction fetch and decode for the accumulator and memory-reference group.
// Operation
// - Prefetch next word while current one executes.
// - Extra cycle when fetch and operand share lines.
// - Group is single cycle; branch class multicycle.
// - Top nibble 0000 is shifted add.
// - Top nibble 0010 is shifted load.
// - Top bits 01101 store upper half, shifted.
// - Two-word 1101 forms: add and load.
// - Two-word 1101 forms: logical AND and OR.
// - Upper byte 01001000 adds to upper half.
// - Upper byte 01001001 unsigned_low_sum_op without sign extension.
// - Upper byte 01001010 adds with register-held shift.
// - Upper byte 01000011 adds with carry.
// - Fixed word CE1B is absolute value.
// - Upper byte CE, low nibble 0010 normalizes.
// - Upper byte CA loads short immediate.
// - Upper byte CC adds short immediate.
// - Direct address is page above seven bits.
module amd_decoder #(
	parameter int PAGE_W = 9,
	parameter int SHIFT_W = 4
) (
	input wire logic mclk,
	input wire logic reset,
	output logic progRead,
	output logic [15:0] progAddr,
	input wire logic [15:0] progWord,
	input wire logic progValid,
	input wire logic progExternal,
	input wire logic operandExternal,
	input wire logic [PAGE_W-1:0] dataPage,
	input wire logic [15:0] auxRegValue,
	input wire logic [SHIFT_W-1:0] tregShift,
	output logic opValid,
	output amd_pkg::amd_op_t opCode,
	output logic [15:0] opWordAddr,
	output logic [SHIFT_W-1:0] shiftAmt,
	output logic memRef,
	output logic indirectMode,
	output logic [6:0] indirectCtrl,
	output logic [15:0] dataAddr,
	output logic [31:0] immValue,
	output logic signExtSuppress,
	output logic carryUse
);
	import amd_pkg::*;

	typedef struct packed {
		amd_state_t state;
		logic [15:0] pc;
		logic [15:0] curAddr;
		logic progRead;
		logic [15:0] progAddr;
		logic awaitImm;
		amd_op_t pendOp;
		logic [SHIFT_W-1:0] pendShift;
		logic [15:0] pendAddr;
		logic [1:0] holdCnt;
		logic opValid;
		amd_op_t opCode;
		logic [15:0] opWordAddr;
		logic [SHIFT_W-1:0] shiftAmt;
		logic memRef;
		logic indirectMode;
		logic [6:0] indirectCtrl;
		logic [15:0] dataAddr;
		logic [31:0] immValue;
		logic signExtSuppress;
		logic carryUse;
	} amd_regs_t;

	amd_regs_t r_q;
	amd_regs_t r_d;

	// Combinational decode of the returned word.
	amd_op_t decOp;
	logic decMem;
	logic decLong;
	logic [SHIFT_W-1:0] decShift;

	always_comb begin
		decOp = otherOp;
		decMem = 1'b0;
		decLong = 1'b0;
		decShift = '0;
		case (1'b1)
			((progWord & MSK_NIBBLE) == PAT_SUM): begin
				decOp = accSumOp;
				decMem = 1'b1;
				decShift = progWord[SHIFT_LSB +: SHIFT_W];
			end
			((progWord & MSK_NIBBLE) == PAT_LOAD): begin
				decOp = shiftedLoadOp;
				decMem = 1'b1;
				decShift = progWord[SHIFT_LSB +: SHIFT_W];
			end
			((progWord & MSK_TOP5) == PAT_HSTORE): begin
				decOp = upperHalfStoreOp;
				decMem = 1'b1;
				decShift = SHIFT_W'(progWord[SHIFT_LSB +: 3]);
			end
			((progWord & MSK_LONG) == PAT_LSUM): begin
				decOp = longImmSumOp;
				decLong = 1'b1;
				decShift = progWord[SHIFT_LSB +: SHIFT_W];
			end
			((progWord & MSK_LONG) == PAT_LLOAD): begin
				decOp = longImmLoadOp;
				decLong = 1'b1;
				decShift = progWord[SHIFT_LSB +: SHIFT_W];
			end
			((progWord & MSK_LONG) == PAT_LAND): begin
				decOp = longImmConjunctionOp;
				decLong = 1'b1;
				decShift = progWord[SHIFT_LSB +: SHIFT_W];
			end
			((progWord & MSK_LONG) == PAT_LOR): begin
				decOp = longImmDisjunctionOp;
				decLong = 1'b1;
				decShift = progWord[SHIFT_LSB +: SHIFT_W];
			end
			((progWord & MSK_BYTE) == PAT_HSUM): begin
				decOp = upperHalfSumOp;
				decMem = 1'b1;
			end
			((progWord & MSK_BYTE) == PAT_USUM): begin
				decOp = unsignedLowSumOp;
				decMem = 1'b1;
			end
			((progWord & MSK_BYTE) == PAT_TSUM): begin
				decOp = tregShiftSumOp;
				decMem = 1'b1;
				decShift = tregShift;
			end
			((progWord & MSK_BYTE) == PAT_CSUM): begin
				decOp = carrySumOp;
				decMem = 1'b1;
			end
			((progWord & MSK_WORD) == PAT_ABS): begin
				decOp = absoluteValueOp;
			end
			((progWord & MSK_NORMALIZE_OP) == PAT_NORMALIZE_OP): begin
				decOp = normalizeOp;
			end
			((progWord & MSK_BYTE) == PAT_SLOAD): begin
				decOp = shortImmLoadOp;
			end
			((progWord & MSK_BYTE) == PAT_SSUM): begin
				decOp = shortImmSumOp;
			end
			((progWord & MSK_NIBBLE) == PAT_MULTI): begin
				decOp = multiCycleOp;
			end
			default: begin
				decOp = otherOp;
			end
		endcase
	end

	always_comb begin
		r_d = r_q;
		r_d.opValid = 1'b0;
		case (r_q.state)
			sStart: begin
				r_d.progRead = 1'b1;
				r_d.progAddr = r_q.pc;
				r_d.curAddr = r_q.pc;
				r_d.pc = r_q.pc + 16'h0001;
				r_d.state = sWait;
			end
			sWait: begin
				if (progValid) begin
					if (r_q.awaitImm) begin
						// Second word becomes the shifted constant.
						r_d.awaitImm = 1'b0;
						r_d.opValid = 1'b1;
						r_d.opCode = r_q.pendOp;
						r_d.opWordAddr = r_q.pendAddr;
						r_d.shiftAmt = r_q.pendShift;
						r_d.memRef = 1'b0;
						r_d.indirectMode = 1'b0;
						r_d.indirectCtrl = 7'h00;
						r_d.dataAddr = 16'h0000;
						r_d.immValue = {16'h0000, progWord} << r_q.pendShift;
						r_d.signExtSuppress = 1'b0;
						r_d.carryUse = 1'b0;
					end else if (decLong) begin
						r_d.awaitImm = 1'b1;
						r_d.pendOp = decOp;
						r_d.pendShift = decShift;
						r_d.pendAddr = r_q.curAddr;
					end else begin
						r_d.opValid = 1'b1;
						r_d.opCode = decOp;
						r_d.opWordAddr = r_q.curAddr;
						r_d.shiftAmt = decShift;
						r_d.memRef = decMem;
						// Mode bit picks direct or indirect.
						r_d.indirectMode = decMem & progWord[MODE_BIT];
						r_d.indirectCtrl = progWord[ADDR_MSB:0];
						if (decMem && progWord[MODE_BIT]) begin
							r_d.dataAddr = auxRegValue;
						end else if (decMem) begin
							r_d.dataAddr = 16'({dataPage, progWord[ADDR_MSB:0]});
						end else begin
							r_d.dataAddr = 16'h0000;
						end
						if (decOp == shortImmLoadOp || decOp == shortImmSumOp) begin
							r_d.immValue = {24'h000000, progWord[BYTE_MSB:0]};
						end else begin
							r_d.immValue = 32'h00000000;
						end
						r_d.signExtSuppress = (decOp == unsignedLowSumOp);
						r_d.carryUse = (decOp == carrySumOp);
					end
					// Multicycle instructions hold the next fetch.
					if (!r_q.awaitImm && decOp == multiCycleOp) begin
						r_d.holdCnt = MULTI_EXTRA;
					// Shared data lines cost a cycle.
					end else if (!r_q.awaitImm && decMem && operandExternal && progExternal) begin
						r_d.holdCnt = SHARE_EXTRA;
					end else begin
						r_d.holdCnt = 2'h0;
					end
					if (r_d.holdCnt != 2'h0) begin
						r_d.progRead = 1'b0;
						r_d.state = sHold;
					end else begin
						// Next word requested as this one issues.
						r_d.progRead = 1'b1;
						r_d.progAddr = r_q.pc;
						r_d.curAddr = r_q.pc;
						r_d.pc = r_q.pc + 16'h0001;
					end
				end
			end
			sHold: begin
				r_d.holdCnt = r_q.holdCnt - 2'h1;
				if (r_q.holdCnt == 2'h1) begin
					r_d.progRead = 1'b1;
					r_d.progAddr = r_q.pc;
					r_d.curAddr = r_q.pc;
					r_d.pc = r_q.pc + 16'h0001;
					r_d.state = sWait;
				end
			end
			default: begin
				r_d.state = sStart;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			r_q <= '{
				state: sStart,
				pc: PC_RESET,
				curAddr: PC_RESET,
				progRead: 1'b0,
				progAddr: PC_RESET,
				awaitImm: 1'b0,
				pendOp: noOp,
				pendShift: '0,
				pendAddr: 16'h0000,
				holdCnt: 2'h0,
				opValid: 1'b0,
				opCode: noOp,
				opWordAddr: 16'h0000,
				shiftAmt: '0,
				memRef: 1'b0,
				indirectMode: 1'b0,
				indirectCtrl: 7'h00,
				dataAddr: 16'h0000,
				immValue: 32'h00000000,
				signExtSuppress: 1'b0,
				carryUse: 1'b0
			};
		end else begin
			r_q <= r_d;
		end
	end

	assign progRead = r_q.progRead;
	assign progAddr = r_q.progAddr;
	assign opValid = r_q.opValid;
	assign opCode = r_q.opCode;
	assign opWordAddr = r_q.opWordAddr;
	assign shiftAmt = r_q.shiftAmt;
	assign memRef = r_q.memRef;
	assign indirectMode = r_q.indirectMode;
	assign indirectCtrl = r_q.indirectCtrl;
	assign dataAddr = r_q.dataAddr;
	assign immValue = r_q.immValue;
	assign signExtSuppress = r_q.signExtSuppress;
	assign carryUse = r_q.carryUse;
endmodule : amd_decoder

// ==== test/amd_decoder_assertions.sv ====
// Port checks for the decoder.
module amd_decoder_assertions #(parameter int PAGE_W = 9, parameter int SHIFT_W = 4) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic progRead,
	input wire logic [15:0] progAddr,
	input wire logic [15:0] progWord,
	input wire logic progValid,
	input wire logic progExternal,
	input wire logic operandExternal,
	input wire logic [PAGE_W-1:0] dataPage,
	input wire logic [15:0] auxRegValue,
	input wire logic opValid,
	input wire amd_pkg::amd_op_t opCode,
	input wire logic [SHIFT_W-1:0] shiftAmt,
	input wire logic indirectMode,
	input wire logic [15:0] dataAddr,
	input wire logic [31:0] immValue
);
	timeunit 1ns;
	timeprecision 1ps;
	import amd_pkg::*;
	logic take, one, long1, immNext_q;
	assign take = progRead && progValid;
	// The word after a long-immediate head is a constant, not an opcode.
	assign one = take && !immNext_q;
	assign long1 = one && progWord[15:12] == 4'hD
		&& progWord[7:0] inside {8'h01, 8'h02, 8'h04, 8'h05};
	always_ff @(posedge mclk or posedge reset)
		if (reset)
			immNext_q <= 1'b0;
		else if (take)
			immNext_q <= long1;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	chk_read_hold: assert property (progRead && !progValid
		|=> progRead && $stable(progAddr)) else $error("fetch dropped early");
	chk_fetch_overlap: assert property (one && progWord[15:12] != 4'hF
		&& !operandExternal |=> progRead && progAddr == $past(progAddr) + 16'h1)
		else $error("no prefetch");
	chk_multi_gap: assert property (one && progWord[15:12] == 4'hF
		|=> !progRead [*2] ##1 progRead) else $error("bad multicycle gap");
	chk_share_gap: assert property (one && progWord[15:12] == 4'h0
		&& operandExternal && progExternal |=> !progRead ##1 progRead)
		else $error("bad shared line gap");
	chk_sum_decode: assert property (one && progWord[15:12] == 4'h0
		|=> opValid && opCode == accSumOp && shiftAmt == $past(progWord[11:8]))
		else $error("bad add decode");
	chk_direct_addr: assert property (one && progWord[15:12] == 4'h0 && !progWord[7]
		|=> !indirectMode && dataAddr == {$past(dataPage), $past(progWord[6:0])})
		else $error("bad direct address");
	chk_indirect_addr: assert property (one && progWord[15:12] == 4'h2 && progWord[7]
		|=> indirectMode && dataAddr == $past(auxRegValue)) else $error("bad indirect");
	chk_head_silent: assert property (long1 |=> !opValid)
		else $error("issue on first word");
	chk_short_imm: assert property (one && progWord[15:8] == 8'hCA
		|=> opValid && opCode == shortImmLoadOp && immValue == {24'h0, $past(progWord[7:0])})
		else $error("bad short load");
	cov_long: cover property (long1);
	cov_multi: cover property (one && progWord[15:12] == 4'hF);
	cov_share: cover property (take && operandExternal && progExternal);
endmodule : amd_decoder_assertions
bind amd_decoder amd_decoder_assertions #(.PAGE_W(PAGE_W), .SHIFT_W(SHIFT_W)) chk (.*);

// ==== test/amd_prog_mem.sv ====
// Program memory model answering fetches after a set number of wait cycles.
module amd_prog_mem (
	input wire logic mclk,
	input wire logic progRead,
	input wire logic [15:0] progAddr,
	output logic [15:0] progWord,
	output logic progValid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:31];
	int waitCycles = 0;
	int cnt = 0;
	initial begin
		progWord = 16'h0000;
		progValid = 1'b0;
	end
	// Outside a valid cycle the word toggles so stale data is never mistaken for fresh.
	always @(negedge mclk) begin
		progValid <= 1'b0;
		progWord <= ~progWord;
		if (progRead === 1'b1 && cnt >= waitCycles) begin
			progValid <= 1'b1;
			progWord <= mem[progAddr[4:0]];
			cnt <= 0;
		end else if (progRead === 1'b1)
			cnt <= cnt + 1;
		else
			cnt <= 0;
	end
endmodule : amd_prog_mem

// ==== test/accumulator_memref_decoder_tb.sv ====
// Self-checking bench for the accumulator and memory-reference decoder.
module accumulator_memref_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import amd_pkg::*;
	logic mclk, reset, progRead, progValid, progExternal, operandExternal, opValid;
	logic memRef, indirectMode, signExtSuppress, carryUse;
	logic [15:0] progAddr, progWord, auxRegValue, opWordAddr, dataAddr;
	logic [8:0] dataPage;
	logic [3:0] tregShift, shiftAmt;
	logic [6:0] indirectCtrl;
	logic [31:0] immValue;
	amd_op_t opCode;
	int miscompares = 0;
	int cmpCount = 0;
	amd_decoder dut (.*);
	amd_prog_mem pm (.*);
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic close_out;
		if (miscompares == 0 && cmpCount > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	task automatic expect_op(amd_op_t op, int gap);
		int n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while (opValid !== 1'b1 && n < 40);
		if (opValid !== 1'b1) begin
			miscompares++;
			close_out();
		end else begin
			check("opCode", opCode, op);
			check("gap", n, gap);
		end
	endtask : expect_op
	task automatic restart(int waits, logic ext);
		@(negedge mclk);
		reset = 1'b1;
		pm.waitCycles = waits;
		progExternal = ext;
		operandExternal = ext;
		repeat (12) @(negedge mclk);
		reset = 1'b0;
	endtask : restart
	task automatic sc_mem_ops;
		expect_op(accSumOp, 2);
		check("shiftAmt", shiftAmt, 4'h1);
		check("dataAddr", dataAddr, {9'h0A5, 7'h23});
		check("memRef", memRef, 1'b1);
		check("indirect", indirectMode, 1'b0);
		check("opWordAddr", opWordAddr, 16'h0000);
		expect_op(shiftedLoadOp, 1);
		check("shiftAmt", shiftAmt, 4'hF);
		check("dataAddr", dataAddr, 16'hBEEF);
		check("indirectCtrl", indirectCtrl, 7'h25);
		check("indirect", indirectMode, 1'b1);
		expect_op(upperHalfStoreOp, 1);
		check("shiftAmt", shiftAmt, 4'h5);
		check("memRef", memRef, 1'b1);
	endtask : sc_mem_ops
	task automatic sc_long_imm;
		amd_op_t ops[4] = '{longImmSumOp, longImmLoadOp, longImmConjunctionOp,
			longImmDisjunctionOp};
		logic [31:0] imms[4] = '{32'h91A0, 32'hFFFF, 32'h40008000, 32'h1FE};
		logic [3:0] shifts[4] = '{4'h3, 4'h0, 4'hF, 4'h1};
		for (int i = 0; i < 4; i++) begin
			expect_op(ops[i], 2);
			check("immValue", immValue, imms[i]);
			check("opWordAddr", opWordAddr, 32'(3 + 2 * i));
			check("shiftAmt", shiftAmt, shifts[i]);
			check("memRef", memRef, 1'b0);
		end
	endtask : sc_long_imm
	task automatic sc_misc_ops;
		expect_op(upperHalfSumOp, 1);
		check("memRef", memRef, 1'b1);
		check("dataAddr", dataAddr, {9'h0A5, 7'h05});
		expect_op(unsignedLowSumOp, 1);
		check("signExt", signExtSuppress, 1'b1);
		expect_op(tregShiftSumOp, 1);
		check("shiftAmt", shiftAmt, 4'h6);
		expect_op(carrySumOp, 1);
		check("carryUse", carryUse, 1'b1);
		expect_op(absoluteValueOp, 1);
		check("memRef", memRef, 1'b0);
		check("carryUse", carryUse, 1'b0);
		check("signExt", signExtSuppress, 1'b0);
		expect_op(normalizeOp, 1);
		expect_op(shortImmLoadOp, 1);
		check("immValue", immValue, 8'h7F);
		expect_op(shortImmSumOp, 1);
		check("immValue", immValue, 8'hFF);
	endtask : sc_misc_ops
	task automatic sc_multi;
		expect_op(multiCycleOp, 1);
		expect_op(accSumOp, 3);
		expect_op(otherOp, 1);
	endtask : sc_multi
	task automatic sc_share;
		restart(1, 1'b1);
		expect_op(accSumOp, 3);
		expect_op(shiftedLoadOp, 3);
		expect_op(upperHalfStoreOp, 3);
	endtask : sc_share
	initial begin
		logic [15:0] prog [22] = '{16'h0123, 16'h2FA5, 16'h6D11, 16'hD302, 16'h1234,
			16'hD001, 16'hFFFF, 16'hDF04, 16'h8001, 16'hD105, 16'h00FF, 16'h4805,
			16'h4986, 16'h4A07, 16'h4308, 16'hCE1B, 16'hCE82, 16'hCA7F, 16'hCCFF,
			16'hF000, 16'h0000, 16'h5000};
		reset = 1'b1;
		dataPage = 9'h0A5;
		auxRegValue = 16'hBEEF;
		tregShift = 4'h6;
		foreach (pm.mem[i])
			pm.mem[i] = 16'hCE1B;
		foreach (prog[i])
			pm.mem[i] = prog[i];
		restart(0, 1'b0);
		sc_mem_ops();
		sc_long_imm();
		sc_misc_ops();
		sc_multi();
		sc_share();
		close_out();
	end
endmodule : accumulator_memref_decoder_tb
